// file: src/vim_pkg.sv
// shared constants of the vectored interrupt priority map
package vim_pkg;
  localparam int NUM_LEVELS = 27;
  localparam int LEVEL_W = 5;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // register byte offsets
  localparam logic [7:0] OFS_REQUEST = 8'h00;
  localparam logic [7:0] OFS_MASK = 8'h04;
  localparam logic [7:0] OFS_PRIO0 = 8'h08;
  localparam logic [7:0] OFS_PRIO1 = 8'h0c;
  localparam logic [7:0] OFS_CONTROL = 8'h10;
  localparam logic [7:0] OFS_VOLTAGE_LEVEL = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  // field positions
  localparam int CTRL_GLOBAL_ENABLE = 0;
  localparam int CTRL_SERVICE0 = 1;
  localparam int CTRL_SERVICE1 = 2;
  localparam int VLR_DETECT_MODE = 7;
  localparam int OPT_WDT_INTERVAL = 7;
  localparam int ST_IRQ = 0;
  localparam int ST_BREAK = 1;
  localparam int ST_RESET = 2;
  localparam int ST_LEVEL_LSB = 8;
  localparam int ST_WDT_EN = 16;
  // reset values
  localparam logic [26:0] RST_REQUEST = 27'h0000000;
  localparam logic [26:0] RST_MASK = 27'h7ffffff;
  localparam logic [26:0] RST_PRIO = 27'h7ffffff;
  localparam logic [1:0] RST_ISP = 2'h3;
  localparam logic [1:0] ISP_NONE = 2'h3;
  localparam logic [7:0] ILLEGAL_OPCODE = 8'hff;
  // default levels of the sources, the first of each run
  localparam int LVL_WDT = 0;
  localparam int LVL_LVI = 1;
  localparam int LVL_PIN0 = 2;
  localparam int LVL_SER0_TX = 8;
  localparam int LVL_SER0_RX = 9;
  localparam int LVL_SER0_ERR = 10;
  localparam int LVL_SER1_TX = 11;
  localparam int LVL_SER1_RX = 12;
  localparam int LVL_TM3_UPPER = 13;
  localparam int LVL_TM0 = 14;
  localparam int LVL_AD = 18;
  localparam int LVL_IT = 19;
  localparam int LVL_KR = 20;
  localparam int LVL_TRJ = 21;
  localparam int LVL_CMP0 = 22;
  localparam int LVL_TRD0 = 24;
  localparam int LVL_FLASH = 26;
  // two-byte vector table entries
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_BREAK = 16'h007e;
  localparam logic [15:0] VEC_TABLE [NUM_LEVELS] = '{
    16'h0004, 16'h0006, 16'h0008, 16'h000a, 16'h000c, 16'h000e, 16'h0010,
    16'h0012, 16'h001e, 16'h0020, 16'h0022, 16'h0024, 16'h0026, 16'h0028,
    16'h002c, 16'h002e, 16'h0030, 16'h0032, 16'h0034, 16'h0038, 16'h003a,
    16'h0040, 16'h0052, 16'h0054, 16'h0056, 16'h0058, 16'h0062};
  typedef enum logic [2:0] {
    VIM_SEL_NONE = 3'b001,
    VIM_SEL_MASKABLE = 3'b010,
    VIM_SEL_BREAK = 3'b100
  } vim_sel_t;
endpackage

// file: src/vim_top.sv
// vectored interrupt source map, priority resolver and vector output
//
// Overview of operation
// - simultaneous requests resolved by priority group, then default level order
// - serial0 tx, clocked serial, two-wire share level 8
// - serial0 receive at level 9, vector 00020
// - serial0 error, timer1 upper share level 10
// - serial1 transmit at level 11, vector 00024
// - serial1 receive and error share level 12
// - timer3 upper byte at level 13, vector 00028
// - timer channels 0 to 3 at levels 14-17
// - conversion done at level 18, vector 00034
// - interval tick level 19, key return level 20
// - capture timers at levels 24 and 25
// - level 26 reserved for flash support request
// - break instruction vectors to 0007e, no level
// - every reset cause vectors to address 00000
// - opcode ff resets unless issued by emulator
// - detect mode bit picks voltage reset or interrupt
// - watchdog interval interrupt only when option bit set
// - acceptance gated by flag, mask, priority, enable, level
// - two priority bits choose one of four groups
// - break accepted while disabled, ignores priority
// - acknowledge clears the source request flag
// - vector entries are two-byte start addresses
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module vim_top #(
  parameter bit HAS_KEY_RETURN = 1'b1
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic [7:0] option_byte_i,
  input wire logic watchdog_interval_irq_i,
  input wire logic voltage_detect_i,
  input wire logic [5:0] pin_edge_irq_i,
  input wire logic serial0_tx_irq_i,
  input wire logic clocked_serial00_irq_i,
  input wire logic two_wire00_irq_i,
  input wire logic serial0_rx_irq_i,
  input wire logic serial0_rx_error_irq_i,
  input wire logic timer_ch1_upper_irq_i,
  input wire logic serial1_tx_irq_i,
  input wire logic serial1_rx_irq_i,
  input wire logic serial1_rx_error_irq_i,
  input wire logic timer_ch3_upper_irq_i,
  input wire logic [3:0] timer_ch_irq_i,
  input wire logic conversion_done_irq_i,
  input wire logic interval_tick_irq_i,
  input wire logic key_return_irq_i,
  input wire logic underflow_timer_irq_i,
  input wire logic [1:0] comparator_irq_i,
  input wire logic capture_timer0_irq_i,
  input wire logic capture_timer1_irq_i,
  input wire logic flash_support_irq_i,
  input wire logic break_instruction_i,
  input wire logic reset_pin_i,
  input wire logic power_on_reset_i,
  input wire logic watchdog_overflow_i,
  input wire logic opcode_exec_i,
  input wire logic [7:0] opcode_i,
  input wire logic emulator_i,
  input wire logic illegal_access_reset_i,
  input wire logic ram_parity_reset_i,
  input wire logic ack_i,
  output logic irq_req_o,
  output logic [15:0] vector_o,
  output logic reset_req_o
);
  localparam int N = vim_pkg::NUM_LEVELS;

  logic [N-1:0] req_flags;
  logic [N-1:0] mask_flag;
  logic [N-1:0] priority_bit0;
  logic [N-1:0] priority_bit1;
  logic global_enable_flag;
  logic in_service_level_bit0;
  logic in_service_level_bit1;
  logic detect_mode_bit;
  logic watchdog_interval_enable;
  logic strap_taken;
  logic break_pend;
  logic [4:0] sel_level;
  vim_pkg::vim_sel_t sel_kind;

  // best eligible level: lowest group value first, then lowest level
  function automatic logic [5:0] pick_level(input logic [26:0] elig,
      input logic [26:0] p0, input logic [26:0] p1);
    logic found;
    logic [1:0] best_grp;
    logic [4:0] best_lvl;
    found = 1'b0;
    best_grp = 2'h3;
    best_lvl = 5'h00;
    for (int l = N - 1; l >= 0; l--) begin
      if (elig[l] && (!found || {p1[l], p0[l]} <= best_grp)) begin
        found = 1'b1;
        best_grp = {p1[l], p0[l]};
        best_lvl = l[4:0];
      end
    end
    return {found, best_lvl};
  endfunction

  // --- register port decode ---
  wire wr_request = wr_i && (addr_i == vim_pkg::OFS_REQUEST);
  wire wr_mask = wr_i && (addr_i == vim_pkg::OFS_MASK);
  wire wr_prio0 = wr_i && (addr_i == vim_pkg::OFS_PRIO0);
  wire wr_prio1 = wr_i && (addr_i == vim_pkg::OFS_PRIO1);
  wire wr_control = wr_i && (addr_i == vim_pkg::OFS_CONTROL);
  wire wr_vlevel = wr_i && (addr_i == vim_pkg::OFS_VOLTAGE_LEVEL);

  // --- source map into request flags ---
  wire [N-1:0] set_ev;
  assign set_ev[vim_pkg::LVL_WDT] = watchdog_interval_irq_i &&
      watchdog_interval_enable;
  assign set_ev[vim_pkg::LVL_LVI] = voltage_detect_i &&
      !detect_mode_bit;
  assign set_ev[vim_pkg::LVL_PIN0 +: 6] = pin_edge_irq_i;
  assign set_ev[vim_pkg::LVL_SER0_TX] = serial0_tx_irq_i ||
      clocked_serial00_irq_i || two_wire00_irq_i;
  assign set_ev[vim_pkg::LVL_SER0_RX] = serial0_rx_irq_i;
  assign set_ev[vim_pkg::LVL_SER0_ERR] = serial0_rx_error_irq_i ||
      timer_ch1_upper_irq_i;
  assign set_ev[vim_pkg::LVL_SER1_TX] = serial1_tx_irq_i;
  assign set_ev[vim_pkg::LVL_SER1_RX] = serial1_rx_irq_i ||
      serial1_rx_error_irq_i;
  assign set_ev[vim_pkg::LVL_TM3_UPPER] = timer_ch3_upper_irq_i;
  assign set_ev[vim_pkg::LVL_TM0 +: 4] = timer_ch_irq_i;
  assign set_ev[vim_pkg::LVL_AD] = conversion_done_irq_i;
  assign set_ev[vim_pkg::LVL_IT] = interval_tick_irq_i;
  // smaller packages have no key-return pins, so the level never fires
  assign set_ev[vim_pkg::LVL_KR] = key_return_irq_i &&
      HAS_KEY_RETURN;
  assign set_ev[vim_pkg::LVL_TRJ] = underflow_timer_irq_i;
  assign set_ev[vim_pkg::LVL_CMP0 +: 2] = comparator_irq_i;
  assign set_ev[vim_pkg::LVL_TRD0] = capture_timer0_irq_i;
  assign set_ev[vim_pkg::LVL_TRD0 + 1] = capture_timer1_irq_i;
  assign set_ev[vim_pkg::LVL_FLASH] = flash_support_irq_i;

  // --- reset causes ---
  wire trap_ev = opcode_exec_i && (opcode_i == vim_pkg::ILLEGAL_OPCODE) &&
      !emulator_i;
  wire volt_reset_ev = voltage_detect_i && detect_mode_bit;
  wire any_reset_ev = reset_pin_i || power_on_reset_i || volt_reset_ev ||
      watchdog_overflow_i || trap_ev || illegal_access_reset_i ||
      ram_parity_reset_i;

  // --- acknowledge and flag update; an event beats any clear ---
  wire ack_maskable = ack_i && irq_req_o &&
      (sel_kind == vim_pkg::VIM_SEL_MASKABLE);
  wire ack_break = ack_i && irq_req_o && (sel_kind == vim_pkg::VIM_SEL_BREAK);
  wire [N-1:0] ack_clr = ack_maskable ? (N'(1) << sel_level) : '0;
  wire [N-1:0] kept = wr_request ? wdata_i[N-1:0] : (req_flags & ~ack_clr);
  wire [N-1:0] next_req_flags = kept | set_ev;
  wire next_break_pend = break_instruction_i ||
      (break_pend && !ack_break);

  // --- resolution ---
  wire [1:0] isp = {in_service_level_bit1, in_service_level_bit0};
  wire [N-1:0] grp_ok;
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_grp
      // a group must beat the level in service; none in service takes all
      assign grp_ok[g] = (isp == vim_pkg::ISP_NONE) ||
          ({priority_bit1[g], priority_bit0[g]} < isp);
    end
  endgenerate
  wire [N-1:0] eligible = next_req_flags & ~mask_flag & grp_ok &
      {N{global_enable_flag}};
  wire [5:0] pick = pick_level(eligible, priority_bit0,
      priority_bit1);
  // break skips enable and priority, so it wins over maskable sources
  wire [2:0] next_kind = next_break_pend ? vim_pkg::VIM_SEL_BREAK :
      (pick[5] ? vim_pkg::VIM_SEL_MASKABLE :
      vim_pkg::VIM_SEL_NONE);
  wire [15:0] next_vector = any_reset_ev ? vim_pkg::VEC_RESET :
      (next_break_pend ? vim_pkg::VEC_BREAK :
      vim_pkg::VEC_TABLE[pick[4:0]]);
  wire next_irq = !any_reset_ev && (next_break_pend || pick[5]);

  // --- read mux ---
  wire [31:0] status_word = {15'h0000, watchdog_interval_enable, 3'h0,
      sel_level, 5'h00, reset_req_o, break_pend, irq_req_o};
  wire [31:0] next_rdata =
      !rd_i ? 32'h00000000 :
      (addr_i == vim_pkg::OFS_REQUEST) ? {5'h00, req_flags} :
      (addr_i == vim_pkg::OFS_MASK) ? {5'h00, mask_flag} :
      (addr_i == vim_pkg::OFS_PRIO0) ? {5'h00, priority_bit0} :
      (addr_i == vim_pkg::OFS_PRIO1) ? {5'h00, priority_bit1} :
      (addr_i == vim_pkg::OFS_CONTROL) ? {29'h00000000,
          in_service_level_bit1, in_service_level_bit0, global_enable_flag} :
      (addr_i == vim_pkg::OFS_VOLTAGE_LEVEL) ? {24'h000000,
          detect_mode_bit, 7'h00} :
      (addr_i == vim_pkg::OFS_STATUS) ? status_word : 32'h00000000;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      req_flags <= vim_pkg::RST_REQUEST;
      break_pend <= 1'b0;
    end else begin
      req_flags <= next_req_flags;
      break_pend <= next_break_pend;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mask_flag <= vim_pkg::RST_MASK;
      priority_bit0 <= vim_pkg::RST_PRIO;
      priority_bit1 <= vim_pkg::RST_PRIO;
    end else begin
      if (wr_mask) mask_flag <= wdata_i[N-1:0];
      if (wr_prio0) priority_bit0 <= wdata_i[N-1:0];
      if (wr_prio1) priority_bit1 <= wdata_i[N-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      global_enable_flag <= 1'b0;
      {in_service_level_bit1, in_service_level_bit0} <= vim_pkg::RST_ISP;
      detect_mode_bit <= 1'b0;
    end else begin
      if (wr_control) begin
        global_enable_flag <= wdata_i[vim_pkg::CTRL_GLOBAL_ENABLE];
        in_service_level_bit0 <= wdata_i[vim_pkg::CTRL_SERVICE0];
        in_service_level_bit1 <= wdata_i[vim_pkg::CTRL_SERVICE1];
      end
      if (wr_vlevel) detect_mode_bit <= wdata_i[vim_pkg::VLR_DETECT_MODE];
    end
  end

  // option byte is a strap: caught once, on the first edge after release
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      strap_taken <= 1'b0;
      watchdog_interval_enable <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      watchdog_interval_enable <=
          option_byte_i[vim_pkg::OPT_WDT_INTERVAL];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_req_o <= 1'b0;
      vector_o <= vim_pkg::VEC_RESET;
      reset_req_o <= 1'b0;
      sel_level <= 5'h00;
      sel_kind <= vim_pkg::VIM_SEL_NONE;
      rdata_o <= 32'h00000000;
    end else begin
      irq_req_o <= next_irq;
      vector_o <= next_vector;
      reset_req_o <= any_reset_ev;
      sel_level <= pick[4:0];
      case (next_kind)
        vim_pkg::VIM_SEL_BREAK: sel_kind <= vim_pkg::VIM_SEL_BREAK;
        vim_pkg::VIM_SEL_MASKABLE: sel_kind <= vim_pkg::VIM_SEL_MASKABLE;
        default: sel_kind <= vim_pkg::VIM_SEL_NONE;
      endcase
      rdata_o <= next_rdata;
    end
  end

  // --- checks ---
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  // checks sample pre-edge values, so $past reads the cycle that decided
  wire sel_set = set_ev[sel_level];
  wire quiet_reset = !any_reset_ev;
  wire [1:0] pick_grp = {priority_bit1[pick[4:0]], priority_bit0[pick[4:0]]};

  a_break_vector: assert property (
    break_instruction_i && quiet_reset |=>
    irq_req_o && vector_o == vim_pkg::VEC_BREAK)
    else $error("break did not vector to its entry");
  a_break_disabled: assert property (
    break_instruction_i && !global_enable_flag && quiet_reset |=>
    irq_req_o ##0 sel_kind == vim_pkg::VIM_SEL_BREAK)
    else $error("break refused while interrupts disabled");
  a_reset_vector: assert property (
    any_reset_ev |=> reset_req_o && !irq_req_o &&
    vector_o == vim_pkg::VEC_RESET)
    else $error("reset cause did not vector to zero");
  a_trap_emulator: assert property (
    opcode_exec_i && opcode_i == vim_pkg::ILLEGAL_OPCODE && emulator_i &&
    !reset_pin_i && !power_on_reset_i && !volt_reset_ev &&
    !watchdog_overflow_i && !illegal_access_reset_i &&
    !ram_parity_reset_i |=> !reset_req_o)
    else $error("emulator opcode caused a reset");
  a_voltage_mode: assert property (
    voltage_detect_i && !detect_mode_bit && !wr_request |=>
    req_flags[vim_pkg::LVL_LVI])
    else $error("voltage event lost in interrupt mode");
  a_shared_serial: assert property (
    (clocked_serial00_irq_i || two_wire00_irq_i) |=>
    req_flags[vim_pkg::LVL_SER0_TX])
    else $error("shared serial source did not set its flag");
  // a fresh event on the acknowledged level may legally set it again
  a_ack_clears: assert property (
    ack_maskable && !wr_request && !sel_set |=>
    !req_flags[$past(sel_level)])
    else $error("acknowledged flag not cleared");
  // sel_level is last cycle's pick, so the mask is looked up through pick
  a_enable_gate: assert property (
    irq_req_o && sel_kind == vim_pkg::VIM_SEL_MASKABLE |->
    $past(global_enable_flag) && !$past(mask_flag[pick[4:0]]))
    else $error("maskable request passed a closed gate");
  a_wdt_gate: assert property (
    !watchdog_interval_enable && !req_flags[vim_pkg::LVL_WDT] &&
    !wr_request |=> !req_flags[vim_pkg::LVL_WDT])
    else $error("watchdog interval flag set while disabled");
  a_level_range: assert property (
    irq_req_o && sel_kind == vim_pkg::VIM_SEL_MASKABLE |->
    sel_level < 5'h1b && vector_o == vim_pkg::VEC_TABLE[sel_level])
    else $error("selected level outside the table");
  // a maskable pick must belong to a group above the level in service
  a_group_gate: assert property (
    irq_req_o && sel_kind == vim_pkg::VIM_SEL_MASKABLE |->
    $past(isp) == vim_pkg::ISP_NONE || $past(pick_grp) < $past(isp))
    else $error("request taken below the level in service");

  c_maskable_ack: cover property (ack_maskable);
  c_break_ack: cover property (ack_break);
  c_trap: cover property (trap_ev);
  c_two_pending: cover property ($countones(eligible) > 1);
  c_service_blocks: cover property (global_enable_flag &&
      |(next_req_flags & ~mask_flag) && !pick[5]);
endmodule
`default_nettype wire

// file: sim/vim_core_model.sv
// processor core model: acknowledges presented requests after a delay
`timescale 1ns/10ps
`default_nettype none
module vim_core_model (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic irq_req_i,
  input wire logic [15:0] vector_i,
  input wire logic enable_i,
  input wire logic [1:0] delay_i,
  output logic ack_o,
  output logic taken_o,
  output logic [15:0] taken_vec_o
);
  logic [1:0] cnt;
  // one-cycle ack, then a fresh wait so the next choice is seen first
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ack_o <= 1'b0;
      taken_o <= 1'b0;
      taken_vec_o <= 16'h0000;
      cnt <= 2'h0;
    end else begin
      taken_o <= ack_o;
      if (ack_o) begin
        taken_vec_o <= vector_i;
        ack_o <= 1'b0;
        cnt <= 2'h0;
      end else if (enable_i && irq_req_i) begin
        if (cnt >= delay_i) begin
          ack_o <= 1'b1;
        end else begin
          cnt <= cnt + 2'h1;
        end
      end else begin
        cnt <= 2'h0;
      end
    end
  end
endmodule
`default_nettype wire

// file: sim/vim_top_bench.sv
// self-checking bench of the interrupt priority map
`timescale 1ns/10ps
`default_nettype none
`define CHK(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin \
  n_errors++; $display("wrong value %s expected %h seen %h", what, exp, got); \
  end end
module vim_top_bench;
  logic clk_i = 1'b0, srst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, break_instruction = 1'b0;
  logic core_en = 1'b0, ack, taken, irq_req_o, reset_req_o;
  logic opcode_exec_i = 1'b0, emulator_i = 1'b0;
  logic [7:0] addr_i = 8'h00, option_byte_i = 8'h80, opcode_i = 8'h00;
  logic [31:0] wdata_i = 32'h0, rdata_o;
  logic [26:0] lv = '0;
  logic [4:0] rc = 5'h0;
  logic [1:0] sel = 2'h0, dly = 2'h0;
  logic [15:0] vector_o, tvec;
  int n_errors = 0;
  int num_checks = 0;
  always #50 clk_i = ~clk_i;
  vim_top i_dut (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .option_byte_i(option_byte_i), .watchdog_interval_irq_i(lv[0]),
    .voltage_detect_i(lv[1]), .pin_edge_irq_i(lv[7:2]),
    .serial0_tx_irq_i(lv[8] && sel == 2'h0),
    .clocked_serial00_irq_i(lv[8] && sel == 2'h1),
    .two_wire00_irq_i(lv[8] && sel[1]), .serial0_rx_irq_i(lv[9]),
    .serial0_rx_error_irq_i(lv[10] && !sel[0]),
    .timer_ch1_upper_irq_i(lv[10] && sel[0]), .serial1_tx_irq_i(lv[11]),
    .serial1_rx_irq_i(lv[12] && !sel[0]),
    .serial1_rx_error_irq_i(lv[12] && sel[0]),
    .timer_ch3_upper_irq_i(lv[13]), .timer_ch_irq_i(lv[17:14]),
    .conversion_done_irq_i(lv[18]), .interval_tick_irq_i(lv[19]),
    .key_return_irq_i(lv[20]), .underflow_timer_irq_i(lv[21]),
    .comparator_irq_i(lv[23:22]), .capture_timer0_irq_i(lv[24]),
    .capture_timer1_irq_i(lv[25]), .flash_support_irq_i(lv[26]),
    .break_instruction_i(break_instruction), .reset_pin_i(rc[0]),
    .power_on_reset_i(rc[1]), .watchdog_overflow_i(rc[2]),
    .opcode_exec_i(opcode_exec_i), .opcode_i(opcode_i),
    .emulator_i(emulator_i), .illegal_access_reset_i(rc[3]),
    .ram_parity_reset_i(rc[4]), .ack_i(ack), .irq_req_o(irq_req_o),
    .vector_o(vector_o), .reset_req_o(reset_req_o));
  vim_core_model i_core (.clk_i(clk_i), .srst_i(srst_i),
    .irq_req_i(irq_req_o), .vector_i(vector_o), .enable_i(core_en),
    .delay_i(dly), .ack_o(ack), .taken_o(taken), .taken_vec_o(tvec));
  function automatic logic [15:0] vec(int l);
    logic [15:0] t [8];
    t = '{16'h0038, 16'h003a, 16'h0040, 16'h0052, 16'h0054, 16'h0056,
      16'h0058, 16'h0062};
    if (l < 8) return 16'h0004 + 16'(2 * l);
    if (l < 14) return 16'h001e + 16'(2 * (l - 8));
    if (l < 19) return 16'h002c + 16'(2 * (l - 14));
    return t[l - 19];
  endfunction
  // lowest group wins, then lowest level; -1 when nothing may be taken
  function automatic int best(logic [26:0] f, logic [26:0] p0,
      logic [26:0] p1, logic [1:0] isp);
    int b;
    b = -1;
    for (int l = 0; l < 27; l++) begin
      if (f[l] && (isp == 2'h3 || {p1[l], p0[l]} < isp)) begin
        if (b < 0 || {p1[l], p0[l]} < {p1[b], p0[b]}) b = l;
      end
    end
    return b;
  endfunction
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic bus_wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic bus_rd(logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic look;
    @(posedge clk_i);
    #1;
  endtask
  task automatic pulse(logic [26:0] m, logic b);
    @(posedge clk_i);
    lv <= m;
    break_instruction <= b;
    sel <= 2'($urandom());
    @(posedge clk_i);
    lv <= '0;
    break_instruction <= 1'b0;
    #1;
  endtask
  task automatic wait_take(output logic [15:0] v);
    for (int i = 0; i < 40; i++) begin
      @(posedge clk_i);
      #1;
      if (taken === 1'b1) begin
        v = tvec;
        return;
      end
    end
    n_errors++;
    $display("wait for acknowledge ran out");
    end_sim();
  endtask
  task automatic fire(int k);
    @(posedge clk_i);
    if (k < 5) rc <= 5'h1 << k;
    if (k == 5) lv <= 27'h2;
    if (k > 5) begin
      opcode_exec_i <= 1'b1;
      opcode_i <= (k == 8) ? 8'hfe : 8'hff;
      emulator_i <= (k == 7);
    end
    @(posedge clk_i);
    rc <= 5'h0;
    lv <= '0;
    opcode_exec_i <= 1'b0;
    #1;
  endtask
  initial begin
    logic [31:0] d;
    logic [15:0] v;
    logic [15:0] got [27];
    logic [26:0] f, p0, p1, mk;
    logic [7:0] ofs [8];
    logic [31:0] rv [8];
    int b;
    void'($urandom(8));
    ofs = '{vim_pkg::OFS_REQUEST, vim_pkg::OFS_MASK, vim_pkg::OFS_PRIO0,
      vim_pkg::OFS_PRIO1, vim_pkg::OFS_CONTROL, vim_pkg::OFS_VOLTAGE_LEVEL,
      vim_pkg::OFS_STATUS, 8'h1c};
    rv = '{32'h0, 32'h7ffffff, 32'h7ffffff, 32'h7ffffff, 32'h6, 32'h0,
      32'h10000, 32'h0};
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      bus_rd(ofs[i], d);
      `CHK("reset value", rv[i], d)
    end
    $display("test reset values done");
    bus_wr(vim_pkg::OFS_CONTROL, 32'h7);
    bus_wr(vim_pkg::OFS_MASK, 32'h0);
    core_en <= 1'b1;
    for (int l = 0; l < 27; l++) begin
      dly <= 2'($urandom());
      pulse(27'h1 << l, 1'b0);
      wait_take(got[l]);
    end
    for (int l = 0; l < 27; l++) begin
      if (l < 11) `CHK("vec", vec(l), got[l])
      else if (l < 14) `CHK("vec", vec(l), got[l])
      else if (l < 20) `CHK("vec", vec(l), got[l])
      else `CHK("vec", vec(l), got[l])
    end
    bus_rd(vim_pkg::OFS_REQUEST, d);
    `CHK("flags after ack", 32'h0, d)
    $display("test vector map done");
    for (int k = 0; k < 6; k++) begin
      p0 = (k == 0) ? '1 : 27'($urandom());
      p1 = (k == 0) ? '1 : 27'($urandom());
      f = 27'($urandom()) | (27'h1 << ($urandom() % 27));
      bus_wr(vim_pkg::OFS_PRIO0, {5'h0, p0});
      bus_wr(vim_pkg::OFS_PRIO1, {5'h0, p1});
      pulse(f, 1'b0);
      while (f != '0) begin
        b = best(f, p0, p1, 2'h3);
        wait_take(v);
        `CHK("order", vec(b), v)
        f[b] = 1'b0;
      end
    end
    $display("test simultaneous order done");
    core_en <= 1'b0;
    mk = 27'($urandom());
    f = 27'($urandom()) | 27'h30;
    bus_wr(vim_pkg::OFS_MASK, {5'h0, mk});
    pulse(f, 1'b0);
    for (int i = 0; i < 4; i++) begin
      bus_wr(vim_pkg::OFS_CONTROL, {29'h0, 2'(i), 1'b1});
      look();
      b = best(f & ~mk, p0, p1, 2'(i));
      `CHK("request", (b >= 0), irq_req_o)
      if (b >= 0) `CHK("vector", vec(b), vector_o)
    end
    bus_wr(vim_pkg::OFS_CONTROL, 32'h6);
    look();
    `CHK("disabled", 1'b0, irq_req_o)
    bus_rd(vim_pkg::OFS_REQUEST, d);
    `CHK("flags kept", {5'h0, f}, d)
    pulse('0, 1'b1);
    `CHK("break req", 1'b1, irq_req_o)
    `CHK("break vec", 16'h007e, vector_o)
    bus_rd(vim_pkg::OFS_STATUS, d);
    `CHK("status", 3'h3, d[2:0])
    bus_wr(vim_pkg::OFS_REQUEST, 32'h0);
    bus_wr(vim_pkg::OFS_CONTROL, 32'h7);
    bus_wr(vim_pkg::OFS_MASK, 32'h0);
    core_en <= 1'b1;
    wait_take(v);
    `CHK("break taken", 16'h007e, v)
    pulse(27'h1, 1'b1);
    wait_take(v);
    `CHK("break first", 16'h007e, v)
    wait_take(v);
    `CHK("then level 0", vec(0), v)
    $display("test gating and break done");
    core_en <= 1'b0;
    bus_wr(vim_pkg::OFS_VOLTAGE_LEVEL, 32'h80);
    for (int k = 0; k < 9; k++) begin
      fire(k);
      `CHK("reset req", (k < 7), reset_req_o)
      if (k < 7) `CHK("reset vec", 16'h0000, vector_o)
    end
    bus_rd(vim_pkg::OFS_REQUEST, d);
    `CHK("no voltage flag", 32'h0, d)
    $display("test reset causes done");
    @(posedge clk_i);
    option_byte_i <= 8'h00;
    srst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    bus_wr(vim_pkg::OFS_CONTROL, 32'h7);
    bus_wr(vim_pkg::OFS_MASK, 32'h0);
    pulse(27'h1, 1'b0);
    `CHK("watchdog off", 1'b0, irq_req_o)
    bus_rd(vim_pkg::OFS_STATUS, d);
    `CHK("strap", 1'b0, d[16])
    $display("test strap done");
    end_sim();
  end
endmodule
`default_nettype wire
